// ===== include/icsc_pkg.sv
// types of the input clock switch control
package icsc_pkg;
    // switching policy codes in field order
    typedef enum logic [1:0] {
        MODE_MANUAL,
        MODE_NONREV,
        MODE_REV,
        MODE_RSVD
    } icsc_mode_t;
    typedef logic [2:0] icsc_rank_t;
endpackage

// ===== include/icsc_regs.svh
// register offsets, field positions, write masks and reset values
`ifndef ICSC_REGS_SVH
`define ICSC_REGS_SVH

// ****************************************
// offsets
// ****************************************
`define ICSC_OFS_INSEL 12'h52A
`define ICSC_OFS_HOLDEN 12'h52C
`define ICSC_OFS_FORCE 12'h535
`define ICSC_OFS_SWCTL 12'h536
`define ICSC_OFS_AMSK 12'h537
`define ICSC_OFS_RANKLO 12'h538
`define ICSC_OFS_RANKHI 12'h539
`define ICSC_OFS_HSW 12'h53A
`define ICSC_OFS_THRLO 12'h53B
`define ICSC_OFS_THRHI 12'h53C
`define ICSC_OFS_STAT 12'h5F0
`define ICSC_OFS_IMSK 12'h5F1
`define ICSC_OFS_STATE 12'h5F2

// ****************************************
// implemented bits per register
// ****************************************
`define ICSC_WM_INSEL 8'h07
`define ICSC_WM_HOLDEN 8'h01
`define ICSC_WM_FORCE 8'h01
`define ICSC_WM_SWCTL 8'h07
`define ICSC_WM_RANK 8'h77
`define ICSC_WM_HSW 8'h0F
`define ICSC_WM_THRHI 8'h03
`define ICSC_WM_EVT 8'h07

// ****************************************
// fields and reset values
// ****************************************
`define ICSC_SEAMLESS_BIT 2
`define ICSC_RANK_MAX 3'h4
`define ICSC_RST_HOLDEN 8'h01
`define ICSC_RST_HSW 8'h01
`define ICSC_RST_ZERO 8'h00
`define ICSC_EV_SWITCH 0
`define ICSC_EV_HOLD 1
`define ICSC_EV_NOREF 2

`endif

// ===== rtl/icsc_ctrl.sv
// input clock switch control: selection, holdover entry and registers
//
// Behaviour
// - force bit puts device into holdover
// - policy field: manual, non-revertive, revertive
// - seamless enable turns phase buildout on
// - no phase buildout in zero delay mode
// - signal loss mask hides alarm from selection
// - frequency mask hides alarm from selection
// - frequency mask forced when detection disabled
// - no qualified input leads into holdover
// - inputs 0/1 rank: 0 none, 1-4
// - inputs 2/3 rank in next register
// - automatic picks lowest rank number
// - equal ranks resolved in order 0..3
// - ten-bit threshold split over two registers
// - manual select field picks input 0..3
// - holdover enable gates holdover entry on lost reference
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`include "icsc_regs.svh"
`default_nettype none

module icsc_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // alarm detectors and straps, asynchronous
    input wire logic [3:0] los_alarm,
    input wire logic [3:0] oof_alarm,
    input wire logic [3:0] oof_detect_off,
    input wire logic zero_delay_enable,
    input wire logic [1:0] sel_pins,
    // towards the pll
    output logic [1:0] active_input,
    output logic holdover,
    output logic phase_buildout,
    output logic [9:0] phase_measure_threshold,
    output logic irq
);

    // ****************************************
    // reset release and input synchronisers
    // ****************************************
    logic [1:0] rst_q_r;
    logic rst_s_n;
    logic [14:0] meta_r;
    logic [14:0] sync_r;

    // asynchronous assert, release two edges later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q_r <= 2'h0;
        end else begin
            rst_q_r <= {rst_q_r[0], 1'b1};
        end
    end
    assign rst_s_n = rst_q_r[1];

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            meta_r <= 15'h0000;
            sync_r <= 15'h0000;
        end else begin
            meta_r <= {los_alarm, oof_alarm, oof_detect_off, zero_delay_enable, sel_pins};
            sync_r <= meta_r;
        end
    end

    logic [3:0] los_s;
    logic [3:0] oof_s;
    logic [3:0] oof_off_s;
    logic zdm_s;
    logic [1:0] pins_s;
    assign los_s = sync_r[14:11];
    assign oof_s = sync_r[10:7];
    assign oof_off_s = sync_r[6:3];
    assign zdm_s = sync_r[2];
    assign pins_s = sync_r[1:0];

    // ****************************************
    // state
    // ****************************************
    logic [7:0] insel_r, insel_nxt, holden_r, holden_nxt, force_r, force_nxt;
    logic [7:0] swctl_r, swctl_nxt, amsk_r, amsk_nxt, ranklo_r, ranklo_nxt;
    logic [7:0] rankhi_r, rankhi_nxt, hsw_r, hsw_nxt, thrlo_r, thrlo_nxt;
    logic [7:0] thrhi_r, thrhi_nxt, stat_r, stat_nxt, imsk_r, imsk_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [1:0] sel_r, sel_nxt;
    logic hold_r, hold_nxt, pb_r, pb_nxt, irq_r, irq_nxt, noref_r, noref_nxt;

    // ****************************************
    // per input qualification
    // ****************************************
    logic [3:0] oof_eff;
    logic [3:0] qual_w;
    logic [3:0] avail_w;
    icsc_pkg::icsc_rank_t rank_w [4];

    // detection off forces the frequency mask
    assign oof_eff = amsk_r[7:4] | oof_off_s;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_in
            localparam int LSB = (g % 2) * 4;
            // low pair in one register, high pair in the next
            assign rank_w[g] = (g < 2) ? ranklo_r[LSB +: 3] : rankhi_r[LSB +: 3];
            assign qual_w[g] = !(los_s[g] && !amsk_r[g])
                && !(oof_s[g] && !oof_eff[g]);
            // reserved codes also count as unranked
            assign avail_w[g] = qual_w[g] && (rank_w[g] != 3'h0)
                && (rank_w[g] <= `ICSC_RANK_MAX);
        end
    endgenerate

    // ****************************************
    // best available input
    // ****************************************
    logic [1:0] best_w;
    icsc_pkg::icsc_rank_t best_rank;
    logic any_w;

    // strict compare keeps the earlier input on a tie
    always_comb begin
        best_w = 2'h0;
        best_rank = 3'h7;
        any_w = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (avail_w[i] && (!any_w || rank_w[i] < best_rank)) begin
                best_w = 2'(i);
                best_rank = rank_w[i];
                any_w = 1'b1;
            end
        end
    end

    // ****************************************
    // next state
    // ****************************************
    icsc_pkg::icsc_mode_t mode_w;
    logic [1:0] man_sel;
    logic noref_w;
    logic [7:0] clr_w;
    logic [7:0] ev_w;

    always_comb begin
        insel_nxt = insel_r;
        holden_nxt = holden_r;
        force_nxt = force_r;
        swctl_nxt = swctl_r;
        amsk_nxt = amsk_r;
        ranklo_nxt = ranklo_r;
        rankhi_nxt = rankhi_r;
        hsw_nxt = hsw_r;
        thrlo_nxt = thrlo_r;
        thrhi_nxt = thrhi_r;
        imsk_nxt = imsk_r;
        sel_nxt = sel_r;
        noref_w = 1'b0;
        clr_w = 8'h00;
        rdata_nxt = 8'h00;
        mode_w = icsc_pkg::icsc_mode_t'(swctl_r[1:0]);
        // register select overrides the pins
        man_sel = insel_r[0] ? insel_r[2:1] : pins_s;
        unique case (mode_w)
            icsc_pkg::MODE_MANUAL: begin
                sel_nxt = man_sel;
                noref_w = !qual_w[man_sel];
            end
            icsc_pkg::MODE_NONREV: begin
                // leave a valid input alone
                if (!avail_w[sel_r] && any_w) begin
                    sel_nxt = best_w;
                end
                noref_w = !any_w;
            end
            icsc_pkg::MODE_REV: begin
                if (any_w) begin
                    sel_nxt = best_w;
                end
                noref_w = !any_w;
            end
            icsc_pkg::MODE_RSVD: begin
                // reserved code freezes the selection
                noref_w = !avail_w[sel_r];
            end
        endcase
        // force wins even with holdover disabled
        hold_nxt = force_r[0]
            || (holden_r[0] && noref_w);
        pb_nxt = swctl_r[`ICSC_SEAMLESS_BIT] && !zdm_s;
        noref_nxt = noref_w;
        if (reg_wr) begin
            unique case (reg_addr)
                `ICSC_OFS_INSEL: insel_nxt = reg_wdata & `ICSC_WM_INSEL;
                `ICSC_OFS_HOLDEN: holden_nxt = reg_wdata & `ICSC_WM_HOLDEN;
                `ICSC_OFS_FORCE: force_nxt = reg_wdata & `ICSC_WM_FORCE;
                `ICSC_OFS_SWCTL: swctl_nxt = reg_wdata & `ICSC_WM_SWCTL;
                `ICSC_OFS_AMSK: amsk_nxt = reg_wdata;
                `ICSC_OFS_RANKLO: ranklo_nxt = reg_wdata & `ICSC_WM_RANK;
                `ICSC_OFS_RANKHI: rankhi_nxt = reg_wdata & `ICSC_WM_RANK;
                // low four bits stored as written, software keeps 1 and 0
                `ICSC_OFS_HSW: hsw_nxt = reg_wdata & `ICSC_WM_HSW;
                `ICSC_OFS_THRLO: thrlo_nxt = reg_wdata;
                `ICSC_OFS_THRHI: thrhi_nxt = reg_wdata & `ICSC_WM_THRHI;
                `ICSC_OFS_STAT: clr_w = reg_wdata & `ICSC_WM_EVT;
                `ICSC_OFS_IMSK: imsk_nxt = reg_wdata & `ICSC_WM_EVT;
                default: clr_w = 8'h00;
            endcase
        end
        // events: selection moved, holdover entered, last reference lost
        ev_w = 8'h00;
        ev_w[`ICSC_EV_SWITCH] = sel_nxt != sel_r;
        ev_w[`ICSC_EV_HOLD] = hold_nxt && !hold_r;
        ev_w[`ICSC_EV_NOREF] = noref_w && !noref_r;
        // a new event beats a clear in the same cycle
        stat_nxt = (stat_r & ~clr_w) | ev_w;
        irq_nxt = |(stat_nxt & imsk_nxt);
        if (reg_rd) begin
            unique case (reg_addr)
                `ICSC_OFS_INSEL: rdata_nxt = insel_r;
                `ICSC_OFS_HOLDEN: rdata_nxt = holden_r;
                `ICSC_OFS_FORCE: rdata_nxt = force_r;
                `ICSC_OFS_SWCTL: rdata_nxt = swctl_r;
                `ICSC_OFS_AMSK: rdata_nxt = {oof_eff, amsk_r[3:0]};
                `ICSC_OFS_RANKLO: rdata_nxt = ranklo_r;
                `ICSC_OFS_RANKHI: rdata_nxt = rankhi_r;
                `ICSC_OFS_HSW: rdata_nxt = hsw_r;
                `ICSC_OFS_THRLO: rdata_nxt = thrlo_r;
                `ICSC_OFS_THRHI: rdata_nxt = thrhi_r;
                `ICSC_OFS_STAT: rdata_nxt = stat_r;
                `ICSC_OFS_IMSK: rdata_nxt = imsk_r;
                `ICSC_OFS_STATE: rdata_nxt = {avail_w, pb_r, hold_r, sel_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // registers only
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            insel_r <= `ICSC_RST_ZERO;
            holden_r <= `ICSC_RST_HOLDEN;
            force_r <= `ICSC_RST_ZERO;
            swctl_r <= `ICSC_RST_ZERO;
            amsk_r <= `ICSC_RST_ZERO;
            ranklo_r <= `ICSC_RST_ZERO;
            rankhi_r <= `ICSC_RST_ZERO;
            hsw_r <= `ICSC_RST_HSW;
            thrlo_r <= `ICSC_RST_ZERO;
            thrhi_r <= `ICSC_RST_ZERO;
            stat_r <= `ICSC_RST_ZERO;
            imsk_r <= `ICSC_RST_ZERO;
            rdata_r <= `ICSC_RST_ZERO;
            sel_r <= 2'h0;
            hold_r <= 1'b0;
            pb_r <= 1'b0;
            irq_r <= 1'b0;
            noref_r <= 1'b0;
        end else begin
            insel_r <= insel_nxt;
            holden_r <= holden_nxt;
            force_r <= force_nxt;
            swctl_r <= swctl_nxt;
            amsk_r <= amsk_nxt;
            ranklo_r <= ranklo_nxt;
            rankhi_r <= rankhi_nxt;
            hsw_r <= hsw_nxt;
            thrlo_r <= thrlo_nxt;
            thrhi_r <= thrhi_nxt;
            stat_r <= stat_nxt;
            imsk_r <= imsk_nxt;
            rdata_r <= rdata_nxt;
            sel_r <= sel_nxt;
            hold_r <= hold_nxt;
            pb_r <= pb_nxt;
            irq_r <= irq_nxt;
            noref_r <= noref_nxt;
        end
    end

    // outputs straight from flops
    assign reg_rdata = rdata_r;
    assign active_input = sel_r;
    assign holdover = hold_r;
    assign phase_buildout = pb_r;
    assign phase_measure_threshold = {thrhi_r[1:0], thrlo_r};
    assign irq = irq_r;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_s_n);

    logic auto_w;
    assign auto_w = (mode_w == icsc_pkg::MODE_NONREV) || (mode_w == icsc_pkg::MODE_REV);

    sequence s_force_write;
        reg_wr && reg_addr == `ICSC_OFS_FORCE && reg_wdata[0];
    endsequence
    sequence s_mask_read;
        reg_rd && reg_addr == `ICSC_OFS_AMSK;
    endsequence
    sequence s_thr_write;
        reg_wr && reg_addr == `ICSC_OFS_THRHI;
    endsequence
    // automatic policy with nothing left to pick from
    sequence s_no_reference;
        auto_w && !any_w;
    endsequence

    // a miss below means a selection, holdover, phase buildout or register path broke
    force_hold_a: assert property (s_force_write |-> ##2 holdover)
        else $error("forced holdover not entered");
    manual_sel_a: assert property (mode_w == icsc_pkg::MODE_MANUAL
        |=> active_input == $past(man_sel))
        else $error("manual select not followed");
    buildout_on_a: assert property (swctl_r[2] && !zdm_s |=> phase_buildout)
        else $error("phase buildout not on");
    zero_delay_a: assert property (zdm_s |=> !phase_buildout)
        else $error("phase buildout in zero delay mode");
    loss_drop_a: assert property (auto_w && any_w && los_s[sel_r] && !amsk_r[sel_r]
        |=> active_input != $past(sel_r))
        else $error("input with signal loss kept");
    freq_drop_a: assert property (auto_w && any_w && oof_s[sel_r] && !oof_eff[sel_r]
        |=> active_input != $past(sel_r))
        else $error("input with frequency alarm kept");
    freq_forced_a: assert property (s_mask_read
        |=> (reg_rdata[7:4] & $past(oof_off_s)) == $past(oof_off_s))
        else $error("frequency mask not forced");
    noref_hold_a: assert property (auto_w && !any_w && holden_r[0] |=> holdover)
        else $error("holdover not entered without reference");
    // judged on the pick itself, alarms may change in the very next cycle
    ranked_only_a: assert property (mode_w == icsc_pkg::MODE_REV
        && any_w |-> rank_w[sel_nxt] != 3'h0 && avail_w[sel_nxt])
        else $error("unranked input selected");
    best_pick_a: assert property (mode_w == icsc_pkg::MODE_REV && avail_w[0]
        && avail_w[1] && rank_w[0] == rank_w[1] && rank_w[0] <= best_rank
        |=> active_input == 2'h0)
        else $error("tie not resolved to lower input");
    thr_split_a: assert property (s_thr_write
        |=> phase_measure_threshold[9:8] == $past(reg_wdata[1:0]))
        else $error("threshold high bits not stored");
    hold_gate_a: assert property (!holden_r[0] && !force_r[0] |=> !holdover)
        else $error("holdover entered while disabled");
    stay_put_a: assert property (mode_w == icsc_pkg::MODE_NONREV && avail_w[sel_r]
        |=> $stable(active_input))
        else $error("non-revertive selection moved");

    // the first cycle without a reference must raise its sticky bit
    noref_event_a: assert property (s_no_reference ##0 !noref_r
        |=> stat_r[`ICSC_EV_NOREF])
        else $error("lost reference not flagged");

    // reserved policy code must not walk the selection anywhere
    rsvd_freeze_a: assert property (mode_w == icsc_pkg::MODE_RSVD
        |=> $stable(active_input))
        else $error("reserved policy moved selection");

endmodule

`default_nettype wire

// ===== verif/icsc_refs.sv
// behavioural model of the four reference inputs and their alarm detectors
`timescale 1ns/10ps
`default_nettype none

module icsc_refs (
    // clock
    input wire logic clk,
    // faults commanded by the bench
    input wire logic [3:0] want_los,
    input wire logic [3:0] want_oof,
    input wire logic [3:0] want_off,
    // detector outputs, one bit per input
    output logic [3:0] los_alarm,
    output logic [3:0] oof_alarm,
    output logic [3:0] oof_detect_off
);
    // quiet detectors before the first edge
    initial begin
        los_alarm = 4'h0;
        oof_alarm = 4'h0;
        oof_detect_off = 4'h0;
    end

    // detectors answer one edge late, like a real qualifier would
    always @(posedge clk) begin
        los_alarm <= want_los;
        oof_alarm <= want_oof;
        oof_detect_off <= want_off;
    end
endmodule

`default_nettype wire

// ===== verif/input_clock_switch_control_tb_top.sv
// self-checking testbench of the input clock switch control
`timescale 1ns/10ps
`include "icsc_regs.svh"
`default_nettype none

module input_clock_switch_control_tb_top;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] los_alarm, oof_alarm, oof_detect_off;
    logic [3:0] want_los = 4'h0, want_oof = 4'h0, want_off = 4'h0;
    logic zero_delay_enable = 1'b0;
    logic [1:0] sel_pins = 2'h0;
    logic [1:0] active_input;
    logic holdover, phase_buildout, irq;
    logic [9:0] phase_measure_threshold;
    int miscompares = 0;
    int total_checks = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    icsc_refs refs (.clk(clk), .want_los(want_los), .want_oof(want_oof), .want_off(want_off),
        .los_alarm(los_alarm), .oof_alarm(oof_alarm), .oof_detect_off(oof_detect_off));

    icsc_ctrl DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .los_alarm(los_alarm),
        .oof_alarm(oof_alarm), .oof_detect_off(oof_detect_off),
        .zero_delay_enable(zero_delay_enable), .sel_pins(sel_pins),
        .active_input(active_input), .holdover(holdover), .phase_buildout(phase_buildout),
        .phase_measure_threshold(phase_measure_threshold), .irq(irq));

    // ****************************************
    // bus cycles and comparisons
    // ****************************************
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk_reg(reg_rdata, exp);
    endtask

    // alarms need the model's edge, two sync edges and the register edge; a margin edge on top
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_defaults();
        rd(`ICSC_OFS_HOLDEN, 8'h01);
        rd(`ICSC_OFS_HSW, 8'h01);
        rd(`ICSC_OFS_FORCE, 8'h00);
        rd(`ICSC_OFS_SWCTL, 8'h00);
        rd(12'h5FF, 8'h00);
        chk_out({9'h000, holdover}, 10'h000);
        $display("test defaults done");
    endtask

    task automatic t_fields();
        wr(`ICSC_OFS_THRLO, 8'hA5);
        wr(`ICSC_OFS_THRHI, 8'hFF);
        rd(`ICSC_OFS_THRHI, 8'h03);
        chk_out(phase_measure_threshold, 10'h3A5);
        wr(`ICSC_OFS_RANKLO, 8'hFF);
        rd(`ICSC_OFS_RANKLO, `ICSC_WM_RANK);
        wr(`ICSC_OFS_RANKHI, 8'hFF);
        rd(`ICSC_OFS_RANKHI, `ICSC_WM_RANK);
        wr(`ICSC_OFS_HSW, 8'h01);
        rd(`ICSC_OFS_HSW, 8'h01);
        $display("test fields done");
    endtask

    task automatic t_force_seamless();
        wr(`ICSC_OFS_FORCE, 8'h01);
        settle();
        chk_out({9'h000, holdover}, 10'h001);
        wr(`ICSC_OFS_FORCE, 8'h00);
        wr(`ICSC_OFS_SWCTL, 8'h04);
        settle();
        chk_out({9'h000, holdover}, 10'h000);
        chk_out({9'h000, phase_buildout}, 10'h001);
        @(posedge clk);
        zero_delay_enable <= 1'b1;
        settle();
        chk_out({9'h000, phase_buildout}, 10'h000);
        @(posedge clk);
        zero_delay_enable <= 1'b0;
        wr(`ICSC_OFS_SWCTL, 8'h00);
        settle();
        chk_out({9'h000, phase_buildout}, 10'h000);
        $display("test force and seamless done");
    endtask

    task automatic t_manual();
        for (int i = 0; i < 4; i++) begin
            wr(`ICSC_OFS_INSEL, {5'h00, i[1:0], 1'b1});
            settle();
            chk_out({8'h00, active_input}, {8'h00, i[1:0]});
        end
        // register control off, the pins pick the input
        wr(`ICSC_OFS_INSEL, 8'h00);
        sel_pins <= 2'h2;
        settle();
        chk_out({8'h00, active_input}, 10'h002);
        $display("test manual done");
    endtask

    task automatic t_auto_rev();
        wr(`ICSC_OFS_RANKLO, 8'h20);
        wr(`ICSC_OFS_RANKHI, 8'h12);
        wr(`ICSC_OFS_SWCTL, 8'h02);
        settle();
        chk_out({8'h00, active_input}, 10'h003);
        want_los <= 4'h8;
        settle();
        chk_out({8'h00, active_input}, 10'h001);
        wr(`ICSC_OFS_AMSK, 8'h08);
        settle();
        chk_out({8'h00, active_input}, 10'h003);
        want_oof <= 4'h8;
        settle();
        chk_out({8'h00, active_input}, 10'h001);
        want_off <= 4'h8;
        settle();
        chk_out({8'h00, active_input}, 10'h003);
        rd(`ICSC_OFS_AMSK, 8'h88);
        want_los <= 4'h0;
        want_oof <= 4'h0;
        want_off <= 4'h0;
        wr(`ICSC_OFS_AMSK, 8'h00);
        // inputs 0, 1 and 3 share rank 1: the lowest index wins
        wr(`ICSC_OFS_RANKLO, 8'h11);
        settle();
        chk_out({8'h00, active_input}, 10'h000);
        wr(`ICSC_OFS_RANKLO, 8'h20);
        $display("test automatic revertive done");
    endtask

    task automatic t_nonrev_hold();
        wr(`ICSC_OFS_SWCTL, 8'h01);
        want_los <= 4'h8;
        settle();
        chk_out({8'h00, active_input}, 10'h001);
        want_los <= 4'h0;
        settle();
        chk_out({8'h00, active_input}, 10'h001);
        wr(`ICSC_OFS_IMSK, 8'h00);
        wr(`ICSC_OFS_STAT, 8'h07);
        want_los <= 4'hF;
        settle();
        chk_out({9'h000, holdover}, 10'h001);
        chk_out({9'h000, irq}, 10'h000);
        rd(`ICSC_OFS_STAT, 8'h06);
        wr(`ICSC_OFS_IMSK, 8'h04);
        settle();
        chk_out({9'h000, irq}, 10'h001);
        wr(`ICSC_OFS_STAT, 8'h04);
        settle();
        chk_out({9'h000, irq}, 10'h000);
        wr(`ICSC_OFS_HOLDEN, 8'h00);
        settle();
        chk_out({9'h000, holdover}, 10'h000);
        // reserved policy: input 1 stays picked although it is alarmed
        wr(`ICSC_OFS_SWCTL, 8'h03);
        want_los <= 4'h2;
        settle();
        chk_out({8'h00, active_input}, 10'h001);
        rd(`ICSC_OFS_STATE, 8'hC1);
        want_los <= 4'hF;
        wr(`ICSC_OFS_SWCTL, 8'h01);
        wr(`ICSC_OFS_HOLDEN, 8'h01);
        want_los <= 4'h0;
        settle();
        chk_out({9'h000, holdover}, 10'h000);
        $display("test non-revertive and holdover done");
    endtask

    // ****************************************
    // run control
    // ****************************************
    task automatic conclude();
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // whole run is about two hundred cycles; some twenty-five times that means a hang
    initial begin
        #50000;
        miscompares++;
        conclude();
    end

    // reset three cycles, then the two-flop release and one spare edge
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_defaults();
        t_fields();
        t_force_seamless();
        t_manual();
        t_auto_rev();
        t_nonrev_hold();
        conclude();
    end
endmodule

`default_nettype wire
